// [hdl/ccr_map.vh]
/*
 * constants of the core clock and reset release block: register offsets,
 * field positions, reset values and counts.
 * assumes inclusion by bare name from the design files of this block only.
 */
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CCR_OFS_PMC 12'h000
`define CCR_OFS_STATUS 12'h004

// ----------------------------------------
// power_mgmt_control fields
// ----------------------------------------
`define CCR_MULT_LSB 0
`define CCR_MULT_MSB 5
`define CCR_DSEL_LSB 6
`define CCR_DSEL_MSB 7
`define CCR_HALVE_BIT 8
`define CCR_PMC_WIDTH 9
`define CCR_PMC_RESET 9'h000

// ----------------------------------------
// status fields
// ----------------------------------------
`define CCR_ST_PERIOD_LSB 0
`define CCR_ST_PERIOD_MSB 15
`define CCR_ST_PINS_LSB 16
`define CCR_ST_PINS_MSB 17
`define CCR_ST_IN_RESET_BIT 18
`define CCR_ST_RELEASED_BIT 19

// ----------------------------------------
// counts
// ----------------------------------------
`define CCR_REF_RELEASE_CYCLES 4096
`define CCR_CORE_RELEASE_CYCLES 2
`define CCR_PERIOD_WIDTH 16

`endif

// [hdl/ccr_rate_gen.v]
/*
 * rate generator: turns measured reference period and the loop settings
 * into a one-cycle core clock enable, by a phase accumulator on pclk.
 * assumes ref_tick is already synchronised to pclk and core rate <= pclk.
 */
`timescale 1ns/1ps
`include "ccr_map.vh"

module ccr_rate_gen #(
	parameter PW = `CCR_PERIOD_WIDTH
)(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// reference tick and settings
	input wire ref_tick,
	input wire [5:0] loop_multiplier,
	input wire [3:0] post_divide_factor,
	input wire input_halve_enable,
	// results
	output reg [PW-1:0] ref_period_q,
	output reg core_tick_q
);

// ----------------------------------------
// reference period measurement
// ----------------------------------------
reg [PW-1:0] run_q;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		run_q <= {PW{1'b0}};
		ref_period_q <= {PW{1'b0}};
	end
	else if (ref_tick)
	begin
		ref_period_q <= run_q + {{(PW-1){1'b0}}, 1'b1};
		run_q <= {PW{1'b0}};
	end
	else if (run_q != {PW{1'b1}})
		run_q <= run_q + {{(PW-1){1'b0}}, 1'b1};
end

// ----------------------------------------
// accumulator: f_core = f_in * 2m / 2n
// ----------------------------------------
// threshold = n * (halve ? 2 : 1) * period; step = m each pclk
wire [PW+4:0] base_w = {5'b0_0000, ref_period_q} << input_halve_enable; // R5
wire [PW+4:0] thr_w = base_w * {{(PW+1){1'b0}}, post_divide_factor}; // R2
reg [PW+4:0] acc_q;
wire [PW+5:0] sum_w = {1'b0, acc_q} + {{PW{1'b0}}, loop_multiplier};
wire [PW+5:0] rem_w = sum_w - {1'b0, thr_w};
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		acc_q <= {(PW+5){1'b0}};
		core_tick_q <= 1'b0;
	end
	else if (thr_w == {(PW+5){1'b0}})
	begin
		acc_q <= {(PW+5){1'b0}};
		core_tick_q <= 1'b0;
	end
	else if (sum_w >= {1'b0, thr_w})
	begin
		// over-range ratios saturate at one tick per pclk
		acc_q <= (rem_w >= {1'b0, thr_w}) ? {(PW+5){1'b0}} : rem_w[PW+4:0]; // R2
		core_tick_q <= 1'b1;
	end
	else
	begin
		acc_q <= sum_w[PW+4:0];
		core_tick_q <= 1'b0;
	end
end

endmodule // ccr_rate_gen

// [hdl/ccr_reset_release.v]
/*
 * core reset release: counts reference ticks after the synchronised reset
 * pin rises, then a few core ticks, then releases core reset.
 * assumes both ticks are one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`include "ccr_map.vh"

module ccr_reset_release #(
	parameter REF_CYCLES = `CCR_REF_RELEASE_CYCLES,
	parameter CORE_CYCLES = `CCR_CORE_RELEASE_CYCLES
)(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// inputs
	input wire pin_reset_n,
	input wire ref_tick,
	input wire core_tick,
	// result
	output reg released_q
);

reg [12:0] ref_cnt_q;
reg [1:0] core_cnt_q;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ref_cnt_q <= 13'h0000;
		core_cnt_q <= 2'h0;
		released_q <= 1'b0;
	end
	else if (!pin_reset_n)
	begin
		ref_cnt_q <= 13'h0000;
		core_cnt_q <= 2'h0;
		released_q <= 1'b0;
	end
	else if (ref_cnt_q != REF_CYCLES[12:0])
	begin
		if (ref_tick)
			ref_cnt_q <= ref_cnt_q + 13'h0001; // R10 R17
	end
	else if (core_cnt_q != CORE_CYCLES[1:0])
	begin
		if (core_tick)
			core_cnt_q <= core_cnt_q + 2'h1; // R10
	end
	else
		released_q <= 1'b1; // R10
end

endmodule // ccr_reset_release

// [hdl/ccr_clock_reset.v]
/*
 * core clock generation and reset release, with an apb register slave.
 * the reference clock and board reset are pins, sampled on pclk; the core
 * and peripheral clocks leave as one-cycle enables on pclk.
 * assumes pclk is much faster than the reference clock.
 *
// Notes on behaviour
// R1 - while the reset pin is low the multiplier is loaded from the ratio pins, later software may rewrite it.
// R2 - the oscillator runs at twice multiplier times loop input and core clock is that over twice the post-divide.
// R3 - the divider-select field picks a post-divide of 1, 2, 4 or 8.
// R4 - while reset is active the post-divide is forced to one.
// R5 - the loop input is the reference, or the reference halved when halving is on.
// R6 - the peripheral clock period is exactly two core clock periods.
// R7 - software keeps reference times multiplier under the oscillator limits for the halving setting.
// R8 - the multiplier keeps the oscillator within its grade range.
// R9 - software changes keep the core clock period within the grade limits.
// R10 - core reset is released 4096 reference cycles plus two core cycles after the pin rises.
// R11 - a missed sampling window may add one reference cycle, 4097 at most.
// R12 - later resets hold the pin low at least 4 reference cycles.
// R13 - the reference clock is stable 10 us before reset rises.
// R14 - the ratio pins are final 20 us before reset rises.
// R15 - with a crystal, allow up to 25 ms start-up before the stable interval.
// R16 - at power-up reset stays low 100 us with a stable reference so the loop locks.
// R17 - the reset pin is synchronised and the delay is counted on reference clock edges.
 */
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ccr_map.vh"

module ccr_clock_reset #(
	// multiplier chosen by each ratio pin code
	parameter [5:0] RATIO_MULT_0 = 6'h04,
	parameter [5:0] RATIO_MULT_1 = 6'h08,
	parameter [5:0] RATIO_MULT_2 = 6'h10,
	parameter [5:0] RATIO_MULT_3 = 6'h20,
	parameter REF_CYCLES = `CCR_REF_RELEASE_CYCLES
)(
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	// board pins
	input wire reference_clock_in,
	input wire reset_pin_n,
	input wire [1:0] ratio_select_pins,
	// clock enables and core reset
	output reg core_clk_en_q,
	output reg periph_clk_en_q,
	output reg core_reset_n_q
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// stage one of each chain feeds only stage two
reg ref_meta_q;
reg ref_sync_q;
reg pin_meta_n_q;
reg pin_sync_n_q;
reg [1:0] pins_meta_q;
reg [1:0] pins_sync_q;

// reference clock level
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ref_meta_q <= 1'b0;
		ref_sync_q <= 1'b0;
	end
	else
	begin
		ref_meta_q <= reference_clock_in;
		ref_sync_q <= ref_meta_q; // R17
	end
end

// board reset pin, parked at its asserted level
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pin_meta_n_q <= 1'b0;
		pin_sync_n_q <= 1'b0;
	end
	else
	begin
		pin_meta_n_q <= reset_pin_n;
		pin_sync_n_q <= pin_meta_n_q; // R17
	end
end

// ratio straps
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pins_meta_q <= 2'h0;
		pins_sync_q <= 2'h0;
	end
	else
	begin
		pins_meta_q <= ratio_select_pins;
		pins_sync_q <= pins_meta_q;
	end
end
wire ref_level = ref_sync_q;
wire pin_rst_n = pin_sync_n_q;

// reference edge detect; reset pin release sampled only on reference edges
reg ref_prev_q;
reg pin_rst_ref_n_q;
wire ref_tick = ref_level & ~ref_prev_q;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ref_prev_q <= 1'b0;
		pin_rst_ref_n_q <= 1'b0;
	end
	else
	begin
		ref_prev_q <= ref_level;
		if (!pin_rst_n)
			pin_rst_ref_n_q <= 1'b0;
		else if (ref_tick)
			pin_rst_ref_n_q <= 1'b1; // R11 R17
	end
end
// enters reset at once, leaves only on a reference edge
wire in_reset = ~pin_rst_ref_n_q;

// ----------------------------------------
// power_mgmt_control register
// ----------------------------------------
reg [`CCR_PMC_WIDTH-1:0] pmc_q;
reg [5:0] strap_mult;
always @*
begin
	case (pins_sync_q)
		2'h0: strap_mult = RATIO_MULT_0;
		2'h1: strap_mult = RATIO_MULT_1;
		2'h2: strap_mult = RATIO_MULT_2;
		2'h3: strap_mult = RATIO_MULT_3;
		default: strap_mult = RATIO_MULT_0;
	endcase
end

wire apb_setup = psel & ~penable;
wire apb_done = psel & penable & pready_q;
wire hit_pmc = (paddr == `CCR_OFS_PMC);
wire hit_status = (paddr == `CCR_OFS_STATUS);
// writes land at the access edge only, never in the setup cycle
wire pmc_wr = apb_done & pwrite & hit_pmc;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		pmc_q <= `CCR_PMC_RESET;
	else if (in_reset)
	begin
		// strap sampled on pclk, never under the asynchronous reset
		pmc_q[`CCR_MULT_MSB:`CCR_MULT_LSB] <= strap_mult; // R1
		pmc_q[`CCR_DSEL_MSB:`CCR_DSEL_LSB] <= 2'h0;
		pmc_q[`CCR_HALVE_BIT] <= 1'b0;
	end
	else if (pmc_wr)
		pmc_q <= pwdata[`CCR_PMC_WIDTH-1:0]; // R1
end

wire [5:0] loop_multiplier = pmc_q[`CCR_MULT_MSB:`CCR_MULT_LSB];
wire [1:0] divider_select_field = pmc_q[`CCR_DSEL_MSB:`CCR_DSEL_LSB];
wire input_halve_enable = pmc_q[`CCR_HALVE_BIT];

// post-divide factor 1, 2, 4, 8; forced to 1 in reset
reg [3:0] post_divide_factor;
always @*
begin
	if (in_reset)
		post_divide_factor = 4'h1; // R4
	else
	begin
		case (divider_select_field)
			2'h0: post_divide_factor = 4'h1; // R3
			2'h1: post_divide_factor = 4'h2; // R3
			2'h2: post_divide_factor = 4'h4; // R3
			2'h3: post_divide_factor = 4'h8; // R3
			default: post_divide_factor = 4'h1;
		endcase
	end
end

// ----------------------------------------
// core and peripheral enables
// ----------------------------------------
wire [`CCR_PERIOD_WIDTH-1:0] ref_period;
wire core_tick;

// fractional ratios jitter by one pclk around the mean rate
ccr_rate_gen #(
	.PW(`CCR_PERIOD_WIDTH)
) u_rate (
	.pclk(pclk),
	.presetn(presetn),
	.ref_tick(ref_tick),
	.loop_multiplier(loop_multiplier),
	.post_divide_factor(post_divide_factor),
	.input_halve_enable(input_halve_enable),
	.ref_period_q(ref_period),
	.core_tick_q(core_tick)
);

// peripheral enable on every second core enable
reg periph_phase_q;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		periph_phase_q <= 1'b0;
		core_clk_en_q <= 1'b0;
		periph_clk_en_q <= 1'b0;
	end
	else
	begin
		core_clk_en_q <= core_tick; // R2
		periph_clk_en_q <= core_tick & periph_phase_q; // R6
		if (core_tick)
			periph_phase_q <= ~periph_phase_q; // R6
	end
end

// ----------------------------------------
// core reset release
// ----------------------------------------
wire released;

ccr_reset_release #(
	.REF_CYCLES(REF_CYCLES),
	.CORE_CYCLES(`CCR_CORE_RELEASE_CYCLES)
) u_release (
	.pclk(pclk),
	.presetn(presetn),
	.pin_reset_n(pin_rst_ref_n_q),
	.ref_tick(ref_tick),
	.core_tick(core_tick),
	.released_q(released)
);

// extra flop so the output leaves straight from a register
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		core_reset_n_q <= 1'b0;
	else
		core_reset_n_q <= released; // R10
end

// ----------------------------------------
// apb slave, one wait-free access phase
// ----------------------------------------
reg [31:0] rd_mux;
always @*
begin
	rd_mux = 32'h0000_0000;
	if (hit_pmc)
		rd_mux[`CCR_PMC_WIDTH-1:0] = pmc_q;
	else if (hit_status)
	begin
		rd_mux[`CCR_ST_PERIOD_MSB:`CCR_ST_PERIOD_LSB] = ref_period;
		rd_mux[`CCR_ST_PINS_MSB:`CCR_ST_PINS_LSB] = pins_sync_q;
		rd_mux[`CCR_ST_IN_RESET_BIT] = in_reset;
		rd_mux[`CCR_ST_RELEASED_BIT] = core_reset_n_q;
	end
end

// handshake: one access cycle, no wait states
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready_q <= 1'b0;
		pslverr_q <= 1'b0;
	end
	else
	begin
		pready_q <= apb_setup;
		pslverr_q <= apb_setup & ~(hit_pmc | hit_status);
	end
end

// read data taken at setup; a write leaves zeros behind
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata_q <= 32'h0000_0000;
	else if (apb_setup)
		prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
end

endmodule // ccr_clock_reset

// [verification/ccr_chk.sv]
/* checker for ccr_clock_reset: apb timing, enable pairing, core reset release.
   assumes bind onto the block, with REF_CYCLES handed on. */
`timescale 1ns/1ps

module ccr_chk #(
	parameter REF_CYCLES = 4096
)(
	// apb
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] prdata_q,
	input logic pready_q,
	input logic pslverr_q,
	// pins and results
	input logic reference_clock_in,
	input logic reset_pin_n,
	input logic core_clk_en_q,
	input logic periph_clk_en_q,
	input logic core_reset_n_q
);
	// ----
	// helpers
	// ----
	logic [1:0] ref_q;
	logic [15:0] cnt_q;
	logic [1:0] cc_q;
	logic seen_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// seen_q waits for a first periph pulse, so a restarted pairing cannot trip it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_q <= 2'h0;
			cnt_q <= 16'h0000;
			cc_q <= 2'h0;
			seen_q <= 1'h0;
		end
		else
		begin
			ref_q <= {ref_q[0], reference_clock_in};
			cnt_q <= reset_pin_n ? cnt_q + {15'h0, ref_q[0] & ~ref_q[1]} : 16'h0000;
			if (periph_clk_en_q)
				cc_q <= 2'h0;
			else if (core_clk_en_q && cc_q != 2'h3)
				cc_q <= cc_q + 2'h1;
			seen_q <= core_reset_n_q & (seen_q | periph_clk_en_q);
		end
	end

	// ----
	// assertions
	// ----
	AST_ZERO_WAIT: assert property (psel && !penable |=> pready_q)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready_q |=> !pready_q)
		else $error("ready held");
	AST_BAD_ADDR: assert property (psel && penable && pready_q
		|-> pslverr_q == (paddr != 12'h000 && paddr != 12'h004)) else $error("slverr wrong");
	AST_BAD_READ: assert property (pslverr_q && !pwrite |-> prdata_q == 32'h0000_0000)
		else $error("data on error");
	AST_PERIPH_CORE: assert property (periph_clk_en_q |-> core_clk_en_q)
		else $error("periph alone");
	AST_PERIPH_SECOND: assert property (periph_clk_en_q && seen_q |-> cc_q == 2'h1)
		else $error("periph not every second");
	AST_PIN_HOLDS: assert property ((!reset_pin_n) [*6] |-> !core_reset_n_q)
		else $error("core reset free");
	AST_RELEASE_COUNT: assert property ($rose(core_reset_n_q)
		|-> cnt_q >= REF_CYCLES && cnt_q <= REF_CYCLES + 3) else $error("release count");
endmodule // ccr_chk

bind ccr_clock_reset ccr_chk #(.REF_CYCLES(REF_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q),
	.pready_q(pready_q), .pslverr_q(pslverr_q), .reference_clock_in(reference_clock_in),
	.reset_pin_n(reset_pin_n), .core_clk_en_q(core_clk_en_q),
	.periph_clk_en_q(periph_clk_en_q), .core_reset_n_q(core_reset_n_q));

// [verification/ccr_board.sv]
/* board model: free-running reference clock, reset pin and ratio straps.
   assumes the bench calls board_reset for each reset. */
`timescale 1ns/1ps

module ccr_board #(
	parameter real HALF_NS = 50.0
)(
	// pins to the block
	output reg reference_clock_in,
	output reg reset_pin_n,
	output reg [1:0] ratio_select_pins
);
	initial
	begin
		reference_clock_in = 1'h0;
		reset_pin_n = 1'h0;
		ratio_select_pins = 2'h0;
		#1.3;
		forever #HALF_NS reference_clock_in = ~reference_clock_in;
	end

	// straps settle at the fall; rise lands 10 ns before a reference low
	task board_reset(input [1:0] code, input integer hold_us);
		begin
			@(negedge reference_clock_in);
			reset_pin_n = 1'h0;
			ratio_select_pins = code;
			#(hold_us * 1000);
			@(posedge reference_clock_in);
			#(HALF_NS - 10.0);
			reset_pin_n = 1'h1;
		end
	endtask
endmodule // ccr_board

// [verification/ccr_clock_reset_tb.sv]
/* bench for ccr_clock_reset: apb tasks and board resets.
   assumes the board model on the pins; release count cut to 8. */
`timescale 1ns/1ps

module ccr_clock_reset_tb;
	localparam REF = 8;
	localparam PER = 20;
	reg pclk = 1'h0;
	reg presetn = 1'h0;
	reg psel = 1'h0;
	reg penable = 1'h0;
	reg pwrite = 1'h0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000;
	wire [31:0] prdata_q;
	wire pready_q, pslverr_q, ref_clk, pin_n, core_en, per_en, core_rst_n;
	wire [1:0] straps;
	reg [31:0] rd;
	reg ev;
	integer err_count = 0;
	integer checked = 0;
	integer i, m, h, t, nc, np;

	always #2.5 pclk = ~pclk;

	ccr_clock_reset #(.REF_CYCLES(REF)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.reference_clock_in(ref_clk), .reset_pin_n(pin_n), .ratio_select_pins(straps),
		.core_clk_en_q(core_en), .periph_clk_en_q(per_en), .core_reset_n_q(core_rst_n));
	ccr_board brd (.reference_clock_in(ref_clk), .reset_pin_n(pin_n),
		.ratio_select_pins(straps));

	task check(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp)
			begin
				err_count = err_count + 1;
				$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask

	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'h1;
			@(posedge pclk);
			while (pready_q !== 1'h1)
				@(posedge pclk);
			rd = prdata_q;
			ev = pslverr_q;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask

	task rchk(input [11:0] a, input [31:0] exp, input [31:0] mask);
		begin
			apb(1'h0, a, 32'h0000_0000);
			check(rd & mask, exp);
		end
	endtask

	// 320 cycles span 16 reference periods; one pclk of jitter per edge
	task measure(input integer exp);
		begin
			repeat (400) @(posedge pclk);
			nc = 0;
			np = 0;
			repeat (16 * PER)
			begin
				@(posedge pclk);
				nc = nc + core_en;
				np = np + per_en;
			end
			check({31'h0, nc + 2 >= exp && nc <= exp + 2}, 32'h1);
			check({31'h0, np * 2 + 2 >= nc && np * 2 <= nc + 2}, 32'h1);
		end
	endtask

	task release_time;
		begin
			wait (pin_n === 1'h1);
			t = 0;
			while (core_rst_n !== 1'h1)
			begin
				@(posedge pclk);
				t = t + 1;
			end
			check({31'h0, t >= REF * PER && t <= (REF + 2) * PER + 15}, 32'h1);
		end
	endtask

	task results;
		begin
			$display("checked %0d, mismatches %0d", checked, err_count);
			if (err_count == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// all tests take about 140 us
	initial
	begin
		#400000;
		err_count = err_count + 1;
		results;
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		fork
			brd.board_reset(2'h1, 100);
		join_none
		repeat (2000) @(posedge pclk);
		rchk(12'h004, 32'h0005_0000, 32'h000f_0000);
		apb(1'h1, 12'h000, 32'h0000_00c4);
		rchk(12'h000, 32'h0000_0008, 32'hffff_ffff);
		measure(128);
		release_time;
		rchk(12'h004, 32'h0009_0014, 32'h000f_ffff);
		for (i = 0; i < 4; i = i + 1)
		begin
			h = i % 2;
			m = 8 * (i + 1);
			apb(1'h1, 12'h000, {23'h0, h[0], i[1:0], m[5:0]});
			rchk(12'h000, {23'h0, h[0], i[1:0], m[5:0]}, 32'hffff_ffff);
			measure(16 * m / ((1 << i) * (h + 1)));
		end
		apb(1'h1, 12'h000, 32'hffff_ffff);
		rchk(12'h000, 32'h0000_01ff, 32'hffff_ffff);
		measure(63);
		rchk(12'h008, 32'h0000_0000, 32'hffff_ffff);
		check({31'h0, ev}, 32'h1);
		apb(1'h1, 12'h008, 32'h0000_0000);
		apb(1'h1, 12'h004, 32'h0000_0000);
		rchk(12'h000, 32'h0000_01ff, 32'hffff_ffff);
		rchk(12'h004, 32'h0009_0014, 32'h000f_ffff);
		fork
			brd.board_reset(2'h2, 20);
		join_none
		repeat (400) @(posedge pclk);
		rchk(12'h000, 32'h0000_0010, 32'hffff_ffff);
		release_time;
		results;
	end
endmodule // ccr_clock_reset_tb
